// >>> hw/rcod_top.v
// reference clock output control register and divided clock output
`timescale 1ns/1ps
`include "rcod_map.vh"

module rcod_top #(
  parameter DIV_CNT_W = 15
) (
  // clock and reset
  input  wire                    CLK,
  input  wire                    RST,
  // register port
  input  wire [`RCOD_ADDR_W-1:0] ADDR,
  input  wire [`RCOD_DATA_W-1:0] WDATA,
  input  wire                    WR,
  input  wire                    RD,
  output reg  [`RCOD_DATA_W-1:0] RDATA,
  // base clock qualifiers and device state
  input  wire                    PRI_OSC_TICK,
  input  wire                    SYS_CLK_TICK,
  input  wire                    SLEEP,
  // output pin
  output reg                     REFCLK_OUTPUT_PIN,
  output reg                     REFCLK_OUTPUT_PIN_OE,
  // crystal keep-alive request
  output reg                     XTAL_KEEP_IN_SLEEP
);

  reg  [`RCOD_DATA_W-1:0] ctrl;
  reg                     next_ctrl_pin;
  reg  [`RCOD_DATA_W-1:0] next_rdata;
  wire                    refclk_out_enable;
  wire                    refclk_run_in_sleep;
  wire                    refclk_source_select;
  wire [`RCOD_DIV_W-1:0]  refclk_divisor_code;
  wire                    base_tick;
  wire                    active;
  wire                    div_level;

  assign refclk_out_enable    = ctrl[`RCOD_BIT_OUT_ENABLE];
  assign refclk_run_in_sleep  = ctrl[`RCOD_BIT_RUN_IN_SLEEP];
  assign refclk_source_select = ctrl[`RCOD_BIT_SOURCE_SELECT];
  assign refclk_divisor_code  = ctrl[`RCOD_DIV_MSB:`RCOD_DIV_LSB];

  // primary oscillator tick or system clock tick, chosen by source select, passed with no sync
  assign base_tick = (refclk_source_select == `RCOD_SRC_PRIMARY) ? PRI_OSC_TICK : SYS_CLK_TICK;

  assign active = refclk_out_enable & (~SLEEP | refclk_run_in_sleep);

  rcod_divider #(
    .CNT_W     (DIV_CNT_W)
  ) u_div (
    .CLK       (CLK),
    .RST       (RST),
    .run       (active),
    .code      (refclk_divisor_code),
    .base_tick (base_tick),
    .div_out   (div_level)
  );

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl <= `RCOD_CTRL_RESET;
    end else if (WR && ADDR == `RCOD_ADDR_CTRL) begin
      ctrl <= WDATA & `RCOD_CTRL_WMASK;
    end
  end

  always @* begin
    next_rdata = `RCOD_ZERO16;
    if (!RD) begin
      next_rdata = `RCOD_ZERO16;
    end else if (ADDR == `RCOD_ADDR_CTRL) begin
      next_rdata = ctrl & `RCOD_CTRL_WMASK;
    end else if (ADDR == `RCOD_ADDR_STATUS) begin
      next_rdata[`RCOD_ST_OUT_BIT]    = REFCLK_OUTPUT_PIN;
      next_rdata[`RCOD_ST_ACTIVE_BIT] = active;
      next_rdata[`RCOD_ST_XTAL_BIT]   = XTAL_KEEP_IN_SLEEP;
    end
  end

  always @* begin
    next_ctrl_pin = active ? div_level : 1'b0;
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA                <= `RCOD_ZERO16;
      REFCLK_OUTPUT_PIN    <= 1'b0;
      REFCLK_OUTPUT_PIN_OE <= 1'b0;
      XTAL_KEEP_IN_SLEEP   <= 1'b0;
    end else begin
      RDATA                <= next_rdata;
      REFCLK_OUTPUT_PIN    <= next_ctrl_pin;
      REFCLK_OUTPUT_PIN_OE <= refclk_out_enable;
      XTAL_KEEP_IN_SLEEP   <= refclk_out_enable & refclk_run_in_sleep &
                              (refclk_source_select == `RCOD_SRC_PRIMARY);
    end
  end

endmodule // rcod_top

// >>> hw/rcod_map.vh
// register map, field positions and reset values for the reference clock output divider
`ifndef RCOD_MAP_VH
`define RCOD_MAP_VH

`define RCOD_ADDR_W            4
`define RCOD_ADDR_CTRL         4'h0
`define RCOD_ADDR_STATUS       4'h1
`define RCOD_DATA_W            16

`define RCOD_BIT_OUT_ENABLE    15
`define RCOD_BIT_RESERVED14    14
`define RCOD_BIT_RUN_IN_SLEEP  13
`define RCOD_BIT_SOURCE_SELECT 12
`define RCOD_DIV_MSB           11
`define RCOD_DIV_LSB           8
`define RCOD_DIV_W             4

`define RCOD_CTRL_WMASK        16'hbf00
`define RCOD_CTRL_RESET        16'h0000
`define RCOD_ZERO16            16'h0000

`define RCOD_SRC_PRIMARY       1'b1
`define RCOD_SRC_SYSTEM        1'b0

`define RCOD_ST_OUT_BIT        0
`define RCOD_ST_ACTIVE_BIT     1
`define RCOD_ST_XTAL_BIT       2

`endif

// >>> hw/rcod_divider.v
// power-of-two divider counter for the reference clock
`timescale 1ns/1ps
`include "rcod_map.vh"

module rcod_divider #(
  parameter CNT_W = 15
) (
  // clock and reset
  input  wire                    CLK,
  input  wire                    RST,
  // control
  input  wire                    run,
  input  wire [`RCOD_DIV_W-1:0]  code,
  // base clock qualifier
  input  wire                    base_tick,
  // divided level
  output reg                     div_out
);

  reg  [CNT_W-1:0] count;
  reg              next_div_out;

  always @* begin
    // code 0 passes base_tick, nonzero code n selects counter bit n-1
    if (code == {`RCOD_DIV_W{1'b0}}) begin
      next_div_out = base_tick;
    end else begin
      next_div_out = count[code - 1'b1];
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      count   <= {CNT_W{1'b0}};
      div_out <= 1'b0;
    end else if (!run) begin
      count   <= {CNT_W{1'b0}};
      div_out <= 1'b0;
    end else begin
      if (base_tick) begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      div_out <= next_div_out;
    end
  end

endmodule // rcod_divider

// >>> bench/rcod_props.sv
// checker for the reference clock output divider
`timescale 1ns/1ps
module rcod_props #(parameter DIV_CNT_W = 15) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // register port
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [15:0] RDATA,
  // ticks and device state
  input wire logic        PRI_OSC_TICK,
  input wire logic        SYS_CLK_TICK,
  input wire logic        SLEEP,
  // outputs
  input wire logic        REFCLK_OUTPUT_PIN,
  input wire logic        REFCLK_OUTPUT_PIN_OE,
  input wire logic        XTAL_KEEP_IN_SLEEP
);
  logic [15:0] c;
  wire         p = REFCLK_OUTPUT_PIN;
  wire         t = c[12] ? PRI_OSC_TICK : SYS_CLK_TICK;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // shadow of the control register
  always @(posedge CLK or posedge RST) if (RST) c <= 16'h0000; else if (WR && ADDR == 4'h0) c <= WDATA;
  oe_follow_a: assert property (REFCLK_OUTPUT_PIN_OE == $past(c[15])) else $error("oe wrong");
  off_low_a: assert property (!c[15] [*3] |-> !p) else $error("pin on while off");
  sleep_stop_a: assert property ((SLEEP && !c[13]) [*3] |-> !p) else $error("pin runs in sleep");
  hold_pin_a: assert property ((!t && $stable(c) && $stable(SLEEP)) [*4] |-> $stable(p)) else $error("pin moved");
  xtal_req_a: assert property (XTAL_KEEP_IN_SLEEP == $past(c[15] & c[13] & c[12])) else $error("xtal wrong");
  rsvd_zero_a: assert property ($past(RD && ADDR == 4'h0) |-> !RDATA[14] && RDATA[7:0] == 8'h00) else $error("rsvd");
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000) else $error("rdata not idle");
  read_back_a: assert property (RD && ADDR == 4'h0 |=> RDATA == ($past(c) & 16'hbf00)) else $error("readback");
  cover property (p && SLEEP && c[13]);
  cover property ($rose(p) && !c[12]);
  cover property (RD && ADDR == 4'h0 && c[15]);
endmodule // rcod_props
bind rcod_top rcod_props #(.DIV_CNT_W(DIV_CNT_W)) p_u (.*);

// >>> bench/rcod_pin_rx.sv
// receiver at the clock pin, measures its period
`timescale 1ns/1ps
module rcod_pin_rx (
  // clock
  input wire logic CLK,
  // pin and its enable
  input wire logic pin,
  input wire logic oe,
  // cycles between rising edges
  output int       per
);
  int   n = 0;
  logic last = 1'b0;
  always @(posedge CLK) begin
    n <= n + 1;
    last <= pin & oe;
    if (pin & oe & !last) begin
      per <= n;
      n <= 1;
    end
  end
endmodule // rcod_pin_rx

// >>> bench/testbench.sv
// self-checking bench for the reference clock output divider
`timescale 1ns/1ps
module testbench;
  logic CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, SLEEP = 1'b0, PRI_OSC_TICK = 1'b1, SYS_CLK_TICK = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000, RDATA;
  logic        REFCLK_OUTPUT_PIN, REFCLK_OUTPUT_PIN_OE, XTAL_KEEP_IN_SLEEP;
  int          per, fails = 0, tests_run = 0;
  rcod_top dut_u (.*);
  rcod_pin_rx rx_u (.CLK(CLK), .pin(REFCLK_OUTPUT_PIN), .oe(REFCLK_OUTPUT_PIN_OE), .per(per));
  always #2.5 CLK = ~CLK;
  // system clock stops in sleep
  always @(posedge CLK) SYS_CLK_TICK <= ~SYS_CLK_TICK & ~SLEEP;
  task check(input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task finish_test;
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK) WR <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK) RD <= 1'b0;
    #1 check(RDATA, e);
    @(posedge CLK);
  endtask
  task t_regs;
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'hbf00);
    wr(4'h3, 16'h0000);
    rd(4'h0, 16'hbf00);
    rd(4'h7, 16'h0000);
    rd(4'h1, 16'h0006);
  endtask
  task t_rst;
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    #1 check({13'h0, REFCLK_OUTPUT_PIN_OE, XTAL_KEEP_IN_SLEEP, REFCLK_OUTPUT_PIN}, 16'h0000);
    @(posedge CLK);
    rd(4'h0, 16'h0000);
  endtask
  task t_div(input logic [15:0] v, input logic [15:0] e);
    wr(4'h0, v);
    repeat (3 * e + 8) @(posedge CLK);
    check(per[15:0], e);
  endtask
  task t_sleep;
    wr(4'h0, 16'hb100);
    SLEEP <= 1'b1;
    repeat (12) @(posedge CLK);
    check(per[15:0], 16'h0002);
    check({15'h0, XTAL_KEEP_IN_SLEEP}, 16'h0001);
    wr(4'h0, 16'h8100);
    repeat (8) @(posedge CLK);
    check({15'h0, REFCLK_OUTPUT_PIN}, 16'h0000);
    check({15'h0, REFCLK_OUTPUT_PIN_OE}, 16'h0001);
    wr(4'h0, 16'h0000);
    repeat (4) @(posedge CLK);
    check({15'h0, REFCLK_OUTPUT_PIN_OE}, 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    t_regs;
    t_div(16'h8000, 16'h0002);
    t_div(16'h8300, 16'h0010);
    t_div(16'h9b00, 16'h0800);
    t_rst;
    t_sleep;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    finish_test;
  end
endmodule // testbench
